// *** hcs_standby.sv ***
// Halt release and clock stop controller of the processor core.
// ---------------------------------------------------------------
// Notes on behaviour
// - Leave halt on any selected release condition.
// - Flags and vector identify the release cause.
// - Pending timer carry releases halt at once.
// - Stop instruction halts the crystal oscillator.
// - Stop acts only while chip enable low.
// - Chip enable rising edge ends clock stop.
// - Clock stop suspends processor and peripherals.
// - Power-fail detector idle during clock stop.
// - Power-on reset ends stop, enables detector.
// - Ignored stop loop resets on timer carry.
// - Stop loads control defaults, halt keeps them.
// - Halt stops execution only, peripherals run.
// ---------------------------------------------------------------
`timescale 1ns/100ps
module hcs_standby #(
	parameter int TIMER_PERIOD = hcs_pkg::TIMER_CARRY_CYCLES
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic HALT_EXEC,
	input wire logic [hcs_pkg::REL_SEL_W-1:0] HALT_SEL,
	input wire logic STOP_EXEC,
	input wire logic [hcs_pkg::STOP_OPERAND_W-1:0] STOP_OPERAND,
	input wire logic CE_PIN,
	input wire logic POWER_ON_RESET,
	input wire logic EXTERNAL_INTERRUPT_PIN,
	input wire logic KEY_INPUT,
	input wire logic TIMER_CARRY_CLEAR,
	input wire logic KEY_LATCH_CLEAR,
	input wire logic INTERRUPT_ACK,
	input wire logic CTRL_WRITE,
	input wire logic [hcs_pkg::CTRL_W-1:0] CTRL_WDATA,
	output logic TIMER_CARRY_FLAG,
	output logic KEY_LATCH_FLAG,
	output logic INTERRUPT_VECTOR_REQ,
	output logic CPU_RUN,
	output logic PERIPH_RUN,
	output logic OSC_ENABLE,
	output logic CE_RESET,
	output logic POWER_FAIL_DETECT_ENABLE,
	output logic STOP_OPERAND_BAD,
	output logic [hcs_pkg::CTRL_W-1:0] CTRL_REG,
	output logic [hcs_pkg::REL_SEL_W-1:0] HALT_SEL_ACTIVE
);

	// ---------------------------------------------------------------
	// Internal signals
	// ---------------------------------------------------------------
	hcs_pkg::hcs_state_t state;
	hcs_pkg::hcs_state_t next_state;
	logic carry;
	logic ce_rise;
	logic release_hit;
	logic stop_take;
	logic stop_ignored;
	logic in_run;
	logic in_halt;
	logic in_stop;
	logic in_loop;
	logic stop_entry;
	logic int_release;
	logic ce_release;
	logic loop_release;

	hcs_carry_timer #(
		.PERIOD(TIMER_PERIOD)
	) u_timer (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.run(PERIPH_RUN),
		.carry(carry)
	);

	hcs_ce_edge u_ce (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.ce(CE_PIN),
		.ce_rise(ce_rise)
	);

	// ---------------------------------------------------------------
	// Decoding helpers
	// ---------------------------------------------------------------
	// A cause counts only while its select bit is set in the latched selection.
	function automatic logic cause_hit(
		input logic [hcs_pkg::REL_SEL_W-1:0] sel,
		input logic int_req,
		input logic tmr_req,
		input logic key_req
	);
		cause_hit = (sel[hcs_pkg::REL_INT_BIT] & int_req) |
			(sel[hcs_pkg::REL_TMR_BIT] & tmr_req) |
			(sel[hcs_pkg::REL_KEY_BIT] & key_req);
	endfunction

	// The oscillator and every peripheral clock hang on this one decode.
	function automatic logic clock_stopped(
		input hcs_pkg::hcs_state_t st
	);
		clock_stopped = (st == hcs_pkg::HCS_STOP);
	endfunction

	// ---------------------------------------------------------------
	// State decode
	// ---------------------------------------------------------------
	assign in_run = (state == hcs_pkg::HCS_RUN);
	assign in_halt = (state == hcs_pkg::HCS_HALT);
	assign in_stop = clock_stopped(state);
	assign in_loop = (state == hcs_pkg::HCS_STOP_LOOP);

	// ---------------------------------------------------------------
	// Release causes
	// ---------------------------------------------------------------
	// The flag is examined as it stands, so a carry left set from before halt releases at once.
	assign release_hit = cause_hit(HALT_SEL_ACTIVE, EXTERNAL_INTERRUPT_PIN,
		TIMER_CARRY_FLAG | carry, KEY_LATCH_FLAG | KEY_INPUT);
	assign int_release = in_halt &
		cause_hit(HALT_SEL_ACTIVE, EXTERNAL_INTERRUPT_PIN, 1'b0, 1'b0);

	assign stop_take = STOP_EXEC & ~CE_PIN;
	assign stop_ignored = STOP_EXEC & CE_PIN;
	// Entry is judged in run only; a strobe in any other state is not an instruction.
	assign stop_entry = in_run & stop_take;

	// A power-on reset overrides both wake paths, so neither may also raise the reset pulse.
	assign ce_release = in_stop & ce_rise & ~POWER_ON_RESET;
	assign loop_release = in_loop & carry & ~POWER_ON_RESET;

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			hcs_pkg::HCS_RUN: begin
				if (stop_take) begin
					next_state = hcs_pkg::HCS_STOP;
				end else if (stop_ignored) begin
					next_state = hcs_pkg::HCS_STOP_LOOP;
				end else if (HALT_EXEC) begin
					next_state = hcs_pkg::HCS_HALT;
				end
			end
			hcs_pkg::HCS_HALT: begin
				if (release_hit) begin
					next_state = hcs_pkg::HCS_RUN;
				end
			end
			hcs_pkg::HCS_STOP: begin
				if (ce_rise) begin
					next_state = hcs_pkg::HCS_RUN;
				end
			end
			hcs_pkg::HCS_STOP_LOOP: begin
				if (carry) begin
					next_state = hcs_pkg::HCS_RUN;
				end
			end
			default: begin
				next_state = hcs_pkg::HCS_RUN;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state <= hcs_pkg::HCS_RUN;
		end else if (POWER_ON_RESET) begin
			state <= hcs_pkg::HCS_RUN;
		end else begin
			state <= next_state;
		end
	end

	// A halt instruction latches its release selection for the whole halt.
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			HALT_SEL_ACTIVE <= hcs_pkg::REL_SEL_RESET;
		end else if (in_run && HALT_EXEC && !STOP_EXEC) begin
			HALT_SEL_ACTIVE <= HALT_SEL;
		end
	end

	// ---------------------------------------------------------------
	// Run enables and reset pulse
	// ---------------------------------------------------------------
	assign CPU_RUN = in_run;
	assign PERIPH_RUN = ~in_stop;
	assign OSC_ENABLE = ~in_stop;

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			CE_RESET <= 1'b0;
		end else begin
			CE_RESET <= ce_release | loop_release;
		end
	end

	// The detector stays off through stop so memory survives a low supply.
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			POWER_FAIL_DETECT_ENABLE <= 1'b1;
		end else if (POWER_ON_RESET) begin
			POWER_FAIL_DETECT_ENABLE <= 1'b1;
		end else if (stop_entry) begin
			POWER_FAIL_DETECT_ENABLE <= 1'b0;
		end
	end

	// Only flagged, never corrected: the operand is software's to get right.
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			STOP_OPERAND_BAD <= 1'b0;
		end else if (STOP_EXEC && in_run) begin
			STOP_OPERAND_BAD <= (STOP_OPERAND != hcs_pkg::STOP_OPERAND_ZERO);
		end
	end

	// ---------------------------------------------------------------
	// Control register
	// ---------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			CTRL_REG <= hcs_pkg::CTRL_INIT;
		end else if (POWER_ON_RESET || stop_entry) begin
			CTRL_REG <= hcs_pkg::CTRL_INIT;
		end else if (CTRL_WRITE && in_run) begin
			CTRL_REG <= CTRL_WDATA;
		end
	end

	// ---------------------------------------------------------------
	// Cause flags
	// ---------------------------------------------------------------
	// Set wins over clear so a carry in the clearing cycle is not lost.
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			TIMER_CARRY_FLAG <= 1'b0;
		end else if (carry) begin
			TIMER_CARRY_FLAG <= 1'b1;
		end else if (TIMER_CARRY_CLEAR) begin
			TIMER_CARRY_FLAG <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			KEY_LATCH_FLAG <= 1'b0;
		end else if (KEY_INPUT && PERIPH_RUN) begin
			KEY_LATCH_FLAG <= 1'b1;
		end else if (KEY_LATCH_CLEAR) begin
			KEY_LATCH_FLAG <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			INTERRUPT_VECTOR_REQ <= 1'b0;
		end else if (int_release) begin
			INTERRUPT_VECTOR_REQ <= 1'b1;
		end else if (INTERRUPT_ACK) begin
			INTERRUPT_VECTOR_REQ <= 1'b0;
		end
	end

endmodule

// *** hcs_pkg.sv ***
// Package of constants and types for the halt release and clock stop controller.
package hcs_pkg;

	// ---------------------------------------------------------------
	// Operand and field layout
	// ---------------------------------------------------------------
	localparam int STOP_OPERAND_W = 4;
	localparam logic [3:0] STOP_OPERAND_ZERO = 4'h0;
	localparam int REL_SEL_W = 3;
	localparam int REL_INT_BIT = 2;
	localparam int REL_TMR_BIT = 1;
	localparam int REL_KEY_BIT = 0;

	// ---------------------------------------------------------------
	// Reset values and timing
	// ---------------------------------------------------------------
	localparam logic [2:0] REL_SEL_RESET = 3'h0;
	localparam int CTRL_W = 8;
	localparam logic [7:0] CTRL_INIT = 8'h00;
	localparam int CLK_MHZ = 125;
	localparam int TIMER_CARRY_US = 1000;
	localparam int TIMER_CARRY_CYCLES = TIMER_CARRY_US * CLK_MHZ;

	typedef enum logic [1:0] {
		HCS_RUN,
		HCS_HALT,
		HCS_STOP,
		HCS_STOP_LOOP
	} hcs_state_t;

endpackage

// *** hcs_carry_timer.sv ***
// Periodic timer that raises a one-cycle carry pulse.
`timescale 1ns/100ps
module hcs_carry_timer #(
	parameter int PERIOD = hcs_pkg::TIMER_CARRY_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	output logic carry
);
	localparam int W = $clog2(PERIOD + 1);
	logic [W-1:0] count;

	// The timer is a peripheral, so it keeps counting in halt; it returns to zero at the end of each period, and when run drops.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			carry <= 1'b0;
		end else if (!run) begin
			count <= '0;
			carry <= 1'b0;
		end else if (count == W'(PERIOD - 1)) begin
			count <= '0;
			carry <= 1'b1;
		end else begin
			count <= count + W'(1);
			carry <= 1'b0;
		end
	end
endmodule

// *** hcs_ce_edge.sv ***
// Rising edge detector for the chip-enable pin.
`timescale 1ns/100ps
module hcs_ce_edge (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	output logic ce_rise
);
	logic ce_last;

	// Starting from the idle high level means a pin held high through reset is not taken as an edge.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ce_last <= 1'b1;
		end else begin
			ce_last <= ce;
		end
	end

	assign ce_rise = ce & ~ce_last;
endmodule

// *** hcs_standby_assertions.sv ***
// Port checker of the standby controller.
`timescale 1ns/100ps
module hcs_standby_assertions (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic HALT_EXEC,
	input wire logic [2:0] HALT_SEL,
	input wire logic STOP_EXEC,
	input wire logic CE_PIN,
	input wire logic POWER_ON_RESET,
	input wire logic TIMER_CARRY_CLEAR,
	input wire logic TIMER_CARRY_FLAG,
	input wire logic CPU_RUN,
	input wire logic PERIPH_RUN,
	input wire logic OSC_ENABLE,
	input wire logic CE_RESET,
	input wire logic POWER_FAIL_DETECT_ENABLE,
	input wire logic [7:0] CTRL_REG
);
	// ----
	// Properties
	// ----
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	sequence s_ins;
		CPU_RUN && !POWER_ON_RESET;
	endsequence
	sequence s_ce_rise;
		!OSC_ENABLE && !CE_PIN && !POWER_ON_RESET ##1 CE_PIN && !POWER_ON_RESET;
	endsequence
	property p_stop; s_ins ##0 STOP_EXEC && !CE_PIN |=> !OSC_ENABLE && !PERIPH_RUN; endproperty
	property p_nop; s_ins ##0 STOP_EXEC && CE_PIN |=> OSC_ENABLE && !CPU_RUN; endproperty
	property p_ce; s_ce_rise |=> CE_RESET && CPU_RUN ##1 !CE_RESET; endproperty
	property p_pfd; !OSC_ENABLE |-> !POWER_FAIL_DETECT_ENABLE; endproperty
	property p_init; !OSC_ENABLE |-> CTRL_REG == hcs_pkg::CTRL_INIT; endproperty
	property p_por; POWER_ON_RESET |=> POWER_FAIL_DETECT_ENABLE && CPU_RUN; endproperty
	property p_keep;
		!CPU_RUN && PERIPH_RUN && !POWER_ON_RESET |=> CE_RESET || $stable(CTRL_REG);
	endproperty
	property p_pend;
		s_ins ##0 HALT_EXEC && !STOP_EXEC && HALT_SEL == 3'h2 && TIMER_CARRY_FLAG
			&& !TIMER_CARRY_CLEAR |=> !CPU_RUN ##1 CPU_RUN;
	endproperty
	property p_halt; s_ins ##0 HALT_EXEC && !STOP_EXEC |=> PERIPH_RUN && OSC_ENABLE; endproperty
	property p_ce_pulse; CE_RESET |=> !CE_RESET; endproperty
	property p_loop; CE_RESET && $past(OSC_ENABLE) |-> TIMER_CARRY_FLAG; endproperty
	a_stop: assert property (p_stop) else $error("stop did not halt");
	a_nop: assert property (p_nop) else $error("stop not a nop");
	a_ce: assert property (p_ce) else $error("no ce reset");
	a_pfd: assert property (p_pfd) else $error("detector on in stop");
	a_init: assert property (p_init) else $error("ctrl not init");
	a_por: assert property (p_por) else $error("bad por exit");
	a_keep: assert property (p_keep) else $error("ctrl lost");
	a_pend: assert property (p_pend) else $error("no prompt release");
	a_halt: assert property (p_halt) else $error("halt stopped clock");
	a_ce_pulse: assert property (p_ce_pulse) else $error("ce reset too long");
	a_loop: assert property (p_loop) else $error("loop reset off carry");
endmodule
bind hcs_standby hcs_standby_assertions u_chk (
	.SYS_CLK(SYS_CLK),
	.RST_N(RST_N),
	.HALT_EXEC(HALT_EXEC),
	.HALT_SEL(HALT_SEL),
	.STOP_EXEC(STOP_EXEC),
	.CE_PIN(CE_PIN),
	.POWER_ON_RESET(POWER_ON_RESET),
	.TIMER_CARRY_CLEAR(TIMER_CARRY_CLEAR),
	.TIMER_CARRY_FLAG(TIMER_CARRY_FLAG),
	.CPU_RUN(CPU_RUN),
	.PERIPH_RUN(PERIPH_RUN),
	.OSC_ENABLE(OSC_ENABLE),
	.CE_RESET(CE_RESET),
	.POWER_FAIL_DETECT_ENABLE(POWER_FAIL_DETECT_ENABLE),
	.CTRL_REG(CTRL_REG)
);

// *** hcs_sw_model.sv ***
// Software model that services release causes after a halt.
`timescale 1ns/100ps
module hcs_sw_model (
	input wire logic clk,
	input wire logic en,
	input wire logic run,
	input wire logic iv,
	input wire logic tf,
	input wire logic kf,
	output logic ia,
	output logic tc,
	output logic kc
);
	// ----
	// Poll causes highest first so none is missed
	// ----
	always @(negedge clk) begin
		ia <= en && run && iv;
		tc <= en && run && !iv && tf;
		kc <= en && run && !iv && !tf && kf;
	end
endmodule

// *** hcs_standby_tb.sv ***
// Self-checking bench of the standby controller.
`timescale 1ns/100ps
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin n_fail++; \
	$display("[FAIL] %s exp %h got %h", nm, e, a); end end
module hcs_standby_tb;
	logic SYS_CLK = 0, RST_N = 0, HALT_EXEC = 0, STOP_EXEC = 0, CE_PIN = 1;
	logic POWER_ON_RESET = 0, EXTERNAL_INTERRUPT_PIN = 0, KEY_INPUT = 0;
	logic CTRL_WRITE = 0, sw_en = 0;
	logic [2:0] HALT_SEL = 3'h0;
	logic [7:0] CTRL_WDATA = 8'h00;
	logic [3:0] STOP_OPERAND = hcs_pkg::STOP_OPERAND_ZERO;
	logic TIMER_CARRY_CLEAR, KEY_LATCH_CLEAR, INTERRUPT_ACK, TIMER_CARRY_FLAG;
	logic KEY_LATCH_FLAG, INTERRUPT_VECTOR_REQ, CPU_RUN, PERIPH_RUN, OSC_ENABLE;
	logic CE_RESET, POWER_FAIL_DETECT_ENABLE, STOP_OPERAND_BAD;
	logic [7:0] CTRL_REG;
	logic [2:0] HALT_SEL_ACTIVE;
	int n_fail = 0;
	int checked = 0;
	// ----
	// Design, software model and bus tasks
	// ----
	hcs_standby #(.TIMER_PERIOD(20)) uut (.*);
	hcs_sw_model sw (.clk(SYS_CLK), .en(sw_en), .run(CPU_RUN), .iv(INTERRUPT_VECTOR_REQ),
		.tf(TIMER_CARRY_FLAG), .kf(KEY_LATCH_FLAG), .ia(INTERRUPT_ACK),
		.tc(TIMER_CARRY_CLEAR), .kc(KEY_LATCH_CLEAR));
	always #4 SYS_CLK = ~SYS_CLK;
	task tally_and_finish;
		$display("checks %0d failures %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task ins(input logic h, s, input logic [2:0] sel);
		HALT_EXEC = h;
		STOP_EXEC = s;
		HALT_SEL = sel;
		@(negedge SYS_CLK);
		HALT_EXEC = 0;
		STOP_EXEC = 0;
		`CHK("halted", 1'b0, CPU_RUN)
	endtask
	// A stalled wait counts as a failure and closes the run.
	task wait_on(input logic ce);
		int i;
		for (i = 0; i < 300; i++) begin
			if ((ce ? CE_RESET : CPU_RUN) === 1'b1) break;
			@(negedge SYS_CLK);
		end
		if (i == 300) begin
			n_fail++;
			tally_and_finish;
		end
	endtask
	initial begin
		repeat (6) @(negedge SYS_CLK);
		RST_N = 1;
		`CHK("pfd", 1'b1, POWER_FAIL_DETECT_ENABLE)
		CTRL_WRITE = 1;
		CTRL_WDATA = 8'h5a;
		@(negedge SYS_CLK);
		CTRL_WRITE = 0;
		ins(1, 0, 3'h2);
		wait_on(0);
		`CHK("tflag", 1'b1, TIMER_CARRY_FLAG)
		ins(1, 0, 3'h2);
		@(negedge SYS_CLK);
		`CHK("run", 1'b1, CPU_RUN)
		`CHK("ctrl", 8'h5a, CTRL_REG)
		ins(1, 0, 3'h1);
		`CHK("sel", 3'h1, HALT_SEL_ACTIVE)
		`CHK("periph_halt", 1'b1, PERIPH_RUN)
		KEY_INPUT = 1;
		wait_on(0);
		KEY_INPUT = 0;
		`CHK("key", 1'b1, KEY_LATCH_FLAG)
		ins(1, 0, 3'h4);
		EXTERNAL_INTERRUPT_PIN = 1;
		wait_on(0);
		EXTERNAL_INTERRUPT_PIN = 0;
		`CHK("vec", 1'b1, INTERRUPT_VECTOR_REQ)
		sw_en = 1;
		repeat (8) @(negedge SYS_CLK);
		sw_en = 0;
		`CHK("key", 1'b0, KEY_LATCH_FLAG)
		`CHK("vec", 1'b0, INTERRUPT_VECTOR_REQ)
		CE_PIN = 0;
		ins(0, 1, 3'h0);
		`CHK("osc", 1'b0, OSC_ENABLE)
		`CHK("periph", 1'b0, PERIPH_RUN)
		`CHK("pfd", 1'b0, POWER_FAIL_DETECT_ENABLE)
		`CHK("ctrl", 8'h00, CTRL_REG)
		`CHK("opnd", 1'b0, STOP_OPERAND_BAD)
		repeat (3) @(negedge SYS_CLK);
		CE_PIN = 1;
		wait_on(1);
		`CHK("run", 1'b1, CPU_RUN)
		@(negedge SYS_CLK);
		`CHK("ce_reset", 1'b0, CE_RESET)
		`CHK("pfd", 1'b0, POWER_FAIL_DETECT_ENABLE)
		ins(0, 1, 3'h0);
		`CHK("osc", 1'b1, OSC_ENABLE)
		wait_on(1);
		`CHK("run", 1'b1, CPU_RUN)
		CE_PIN = 0;
		ins(0, 1, 3'h0);
		POWER_ON_RESET = 1;
		@(negedge SYS_CLK);
		POWER_ON_RESET = 0;
		`CHK("pfd", 1'b1, POWER_FAIL_DETECT_ENABLE)
		`CHK("osc", 1'b1, OSC_ENABLE)
		tally_and_finish;
	end
endmodule
